// *** shared/srst_pkg.sv ***
// Functional notes
// - Four active-low resets from the slow clock.
// - Processor reset also resets the watchdog.
// - Pin sampled on slow clock; low requests user reset.
// - User reset disabled ignores low pin.
// - Status shows present pin level.
// - Sticky pin-fall bit, cleared by status read.
// - Interrupt may replace user reset.
// - Pin pulse lasts two to the power length-plus-one cycles.
// - Length zero gives two-cycle pulse.
// - Mode register cleared only by backup reset.
// - Boot pin sampled three cycles after core rise.
// - Cause updated when processor reset releases.
// - General reset: startup count, three cycles, release.
// - Pin rises two cycles after backup release.
// - Backup supply low asserts every reset immediately.
// - Backup detector drives backup reset; released with processor reset.
// - Core supply off holds resets; three-cycle restart.
// - Wake-up pin pulse uses retained length.
// - Core supply fall asserts resets at once.
// - Enabled low pin asserts processor, peripheral resets.
// - User reset ends after resync and three cycles.
// - User cause loaded; external low holds resets.
// - Cause codes: general, wake, watchdog, software, user.
// - Interrupt from sticky bit; status read clears.
`default_nettype none
package srst_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEN_W  = 4;

  // ----------------------------------------------------------------
  // Register map and fields.
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] MODE_OFS   = 8'h08;

  localparam int unsigned SR_SEEN_BIT  = 0;
  localparam int unsigned SR_CAUSE_LSB = 8;
  localparam int unsigned SR_LEVEL_BIT = 16;
  localparam int unsigned MR_UEN_BIT   = 0;
  localparam int unsigned MR_IEN_BIT   = 4;
  localparam int unsigned MR_LEN_LSB   = 8;

  // ----------------------------------------------------------------
  // Reset cause codes.
  // ----------------------------------------------------------------
  typedef logic [2:0] srst_cause_t;
  localparam srst_cause_t CAUSE_GENERAL  = 3'h0;
  localparam srst_cause_t CAUSE_WAKEUP   = 3'h1;
  localparam srst_cause_t CAUSE_WATCHDOG = 3'h2;
  localparam srst_cause_t CAUSE_SOFTWARE = 3'h3;
  localparam srst_cause_t CAUSE_USER     = 3'h4;

  // ----------------------------------------------------------------
  // Timing counts in slow clock cycles.
  // ----------------------------------------------------------------
  localparam logic [1:0]  PROC_START_CYC  = 2'h3;
  localparam logic [1:0]  BOOT_SAMPLE_CYC = 2'h3;
  localparam int unsigned STARTUP_CYC_DEF = 64;

  // ----------------------------------------------------------------
  // Retained mode settings.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             irq_en;
    logic             user_en;
    logic [LEN_W-1:0] len;
  } srst_mode_s;

  localparam srst_mode_s MODE_RESET = '0;

endpackage
`default_nettype wire

// *** logic/srst_startup.sv ***
`timescale 1ns/1ns
`default_nettype none
module srst_startup #(
  parameter int unsigned CYCLES = srst_pkg::STARTUP_CYC_DEF
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Count control and result.
  input  wire logic enable,
  output logic      done
);
  import srst_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Counts slow clock cycles while the backup supply stays good.
  assign done  = (cnt_q == LAST);
  assign cnt_d = !enable ? '0 : (done ? cnt_q : cnt_q + CW'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// *** logic/srst_pin_mgr.sv ***
`timescale 1ns/1ns
`default_nettype none
module srst_pin_mgr (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Requests from the sequencer.
  input  wire logic                 ext_req,
  input  wire logic                 force_low,
  input  wire srst_pkg::srst_mode_s mode,
  // Reset pin.
  input  wire logic                 pin_in,
  output logic                      pin_out,
  output logic                      pin_oe,
  // Sampled pin state.
  output logic                      pin_level,
  output logic                      pin_fall,
  output logic                      self_drive,
  output logic                      pin_busy
);
  import srst_pkg::*;

  localparam int unsigned CNT_W = (1 << LEN_W) + 1;

  logic             meta_q;
  logic             sync_q;
  logic             prev_q;
  logic [1:0]       hist_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [LEN_W:0]   shift;
  logic [CNT_W-1:0] pulse_cyc;

  // ----------------------------------------------------------------
  // Pulse length and drive.
  // ----------------------------------------------------------------
  assign shift      = {1'b0, mode.len} + (LEN_W+1)'(1);
  assign pulse_cyc  = CNT_W'(1) << shift;
  assign cnt_d      = ext_req ? pulse_cyc : ((cnt_q != '0) ? cnt_q - CNT_W'(1) : '0);
  assign self_drive = ext_req | (cnt_q != '0);
  assign pin_busy   = self_drive | (|hist_q);
  assign pin_out    = 1'b0;
  assign pin_oe     = self_drive | force_low;
  assign pin_level  = sync_q;
  assign pin_fall   = prev_q & ~sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
      hist_q <= '0;
      cnt_q  <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      hist_q <= {hist_q[0], self_drive};
      cnt_q  <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  chk_short_pulse: assert property (@(posedge clk) disable iff (rst)
    $fell(ext_req) && mode.len == '0 |-> self_drive ##1 self_drive ##1 (ext_req || !self_drive))
    else $error("pin pulse for length zero is not two cycles");

endmodule
`default_nettype wire

// *** logic/srst_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module srst_ctrl #(
  parameter int unsigned STARTUP_CYC = srst_pkg::STARTUP_CYC_DEF
) (
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Supply detectors, high while the supply is good.
  input  wire logic                         backup_por_n,
  input  wire logic                         core_por_n,
  // Reset pin and boot select pin.
  input  wire logic                         nrst_in,
  output logic                              nrst_out,
  output logic                              nrst_oe,
  input  wire logic                         boot_select_pin,
  // Reset outputs.
  output logic                              proc_rst_n,
  output logic                              wdt_rst_n,
  output logic                              backup_rst_n,
  output logic                              periph_rst_n,
  // Register port.
  input  wire logic [srst_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [srst_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [srst_pkg::DATA_W-1:0]  reg_rdata,
  // Status.
  output logic                              user_reset_irq,
  output logic                              boot_mode
);
  import srst_pkg::*;

  typedef enum logic [2:0] {
    ST_BACKUP,
    ST_CORE_OFF,
    ST_START,
    ST_RUN,
    ST_USER
  } srst_state_e;

  localparam logic [1:0] START_LAST = PROC_START_CYC - 2'h1;

  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       bk_ok_s;
  logic       core_ok_s;
  logic       boot_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {boot_select_pin, core_por_n, backup_por_n};
      sync_q <= meta_q;
    end
  end

  assign bk_ok_s   = sync_q[0];
  assign core_ok_s = sync_q[1];
  assign boot_s    = sync_q[2];

  // ----------------------------------------------------------------
  // Sequencer state.
  // ----------------------------------------------------------------
  srst_state_e st_q;
  srst_state_e st_d;
  logic [1:0]  cnt_q;
  logic [1:0]  cnt_d;
  srst_cause_t pend_q;
  srst_cause_t pend_d;
  srst_cause_t cause_q;
  srst_cause_t cause_d;
  logic        proc_n_q;
  logic        proc_d;
  logic        bk_n_q;
  logic        bk_d;
  logic        req_q;
  logic        req_d;
  logic        startup_done;
  logic        pin_level;
  logic        pin_fall;
  logic        self_drive;
  logic        pin_busy;
  logic        user_hit;
  srst_mode_s  mode_q;
  srst_mode_s  mode_d;

  srst_startup #(
    .CYCLES (STARTUP_CYC)
  ) u_startup (
    .clk    (clk),
    .rst    (rst),
    .enable (bk_ok_s && st_q == ST_BACKUP),
    .done   (startup_done)
  );

  srst_pin_mgr u_pin (
    .clk        (clk),
    .rst        (rst),
    .ext_req    (req_q),
    .force_low  (~backup_por_n | ~core_por_n),
    .mode       (mode_q),
    .pin_in     (nrst_in),
    .pin_out    (nrst_out),
    .pin_oe     (nrst_oe),
    .pin_level  (pin_level),
    .pin_fall   (pin_fall),
    .self_drive (self_drive),
    .pin_busy   (pin_busy)
  );

  // A low pin only counts when it is not our own pulse echoing back.
  assign user_hit = !pin_level && mode_q.user_en && !pin_busy;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    pend_d = pend_q;
    proc_d = proc_n_q;
    bk_d   = bk_n_q;
    req_d  = 1'b0;
    if (!bk_ok_s) begin
      st_d   = ST_BACKUP;
      proc_d = 1'b0;
      bk_d   = 1'b0;
      req_d  = 1'b1;
      cnt_d  = '0;
    end else if (!core_ok_s && st_q != ST_BACKUP) begin
      st_d   = ST_CORE_OFF;
      proc_d = 1'b0;
      req_d  = 1'b1;
      cnt_d  = '0;
    end else begin
      case (st_q)
        ST_BACKUP: begin
          req_d = 1'b1;
          if (startup_done) begin
            st_d   = ST_START;
            pend_d = CAUSE_GENERAL;
          end
        end
        ST_CORE_OFF: begin
          req_d  = 1'b1;
          st_d   = ST_START;
          pend_d = CAUSE_WAKEUP;
        end
        ST_START: begin
          req_d = 1'b1;
          if (cnt_q == START_LAST) begin
            st_d   = ST_RUN;
            proc_d = 1'b1;
            bk_d   = 1'b1;
            req_d  = 1'b0;
            cnt_d  = '0;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
        ST_RUN: begin
          if (user_hit) begin
            st_d   = ST_USER;
            proc_d = 1'b0;
            req_d  = 1'b1;
            pend_d = CAUSE_USER;
          end
        end
        ST_USER: begin
          if (pin_level && !pin_busy) begin
            st_d = ST_START;
          end
        end
        default: begin
          st_d = ST_BACKUP;
        end
      endcase
    end
  end

  // The cause is taken only on the edge that releases the processor.
  assign cause_d = (proc_d && !proc_n_q) ? pend_q : cause_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q     <= ST_BACKUP;
      cnt_q    <= '0;
      pend_q   <= CAUSE_GENERAL;
      cause_q  <= CAUSE_GENERAL;
      proc_n_q <= 1'b0;
      bk_n_q   <= 1'b0;
      req_q    <= 1'b1;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      pend_q   <= pend_d;
      cause_q  <= cause_d;
      proc_n_q <= proc_d;
      bk_n_q   <= bk_d;
      req_q    <= req_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset outputs.
  // ----------------------------------------------------------------
  assign proc_rst_n   = proc_n_q & backup_por_n & core_por_n;
  assign periph_rst_n = proc_n_q & backup_por_n & core_por_n;
  assign wdt_rst_n    = proc_rst_n;
  assign backup_rst_n = bk_n_q & backup_por_n;

  // ----------------------------------------------------------------
  // Boot select sampling.
  // ----------------------------------------------------------------
  logic       core_prev_q;
  logic [1:0] boot_cnt_q;
  logic [1:0] boot_cnt_d;
  logic       boot_q;
  logic       boot_take;

  assign boot_take  = (boot_cnt_q == BOOT_SAMPLE_CYC);
  assign boot_cnt_d = (core_ok_s && !core_prev_q) ? 2'h1 :
                      (boot_take || boot_cnt_q == 2'h0) ? 2'h0 : boot_cnt_q + 2'h1;
  assign boot_mode  = boot_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      core_prev_q <= 1'b0;
      boot_cnt_q  <= '0;
      boot_q      <= 1'b0;
    end else begin
      core_prev_q <= core_ok_s;
      boot_cnt_q  <= boot_cnt_d;
      boot_q      <= boot_take ? boot_s : boot_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  logic              sr_read;
  logic              mode_wr;
  logic              seen_q;
  logic              seen_d;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] mode_word;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_q;

  assign sr_read = reg_rd && hit(reg_addr, STATUS_OFS);
  assign mode_wr = reg_wr && hit(reg_addr, MODE_OFS);
  assign seen_d  = pin_fall | (seen_q & ~sr_read);

  assign mode_d.irq_en  = reg_wdata[MR_IEN_BIT];
  assign mode_d.user_en = reg_wdata[MR_UEN_BIT];
  assign mode_d.len     = reg_wdata[MR_LEN_LSB +: LEN_W];

  assign status_word = (DATA_W'(seen_q) << SR_SEEN_BIT)
                     | (DATA_W'(cause_q) << SR_CAUSE_LSB)
                     | (DATA_W'(pin_level) << SR_LEVEL_BIT);
  assign mode_word   = (DATA_W'(mode_q.user_en) << MR_UEN_BIT)
                     | (DATA_W'(mode_q.irq_en) << MR_IEN_BIT)
                     | (DATA_W'(mode_q.len) << MR_LEN_LSB);
  assign rd_mux      = !reg_rd ? '0 :
                       hit(reg_addr, STATUS_OFS) ? status_word :
                       hit(reg_addr, MODE_OFS) ? mode_word : '0;
  assign reg_rdata   = rdata_q;

  assign user_reset_irq = seen_q & ~mode_q.user_en & mode_q.irq_en;

  // The mode register lives in the backup domain.
  always_ff @(posedge clk) begin
    if (rst || !bk_n_q) begin
      mode_q <= MODE_RESET;
    end else if (mode_wr) begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seen_q  <= 1'b0;
      rdata_q <= '0;
    end else begin
      seen_q  <= seen_d;
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic st_start;
  assign st_start = (st_q == ST_START);

  sequence held_three;
    !proc_n_q [*3];
  endsequence

  sequence released;
    proc_n_q;
  endsequence

  chk_start_three_cycles: assert property (
    disable iff (rst || !bk_ok_s || !core_ok_s)
    $rose(st_start) |-> held_three ##1 released)
    else $error("processor reset not held for three cycles");

  chk_backup_drops_all: assert property (
    !backup_por_n |-> !proc_rst_n && !periph_rst_n && !backup_rst_n && nrst_oe)
    else $error("backup supply low did not assert all resets");

  chk_core_drops_resets: assert property (
    !core_por_n |-> !proc_rst_n && !periph_rst_n && nrst_oe)
    else $error("core supply low did not assert resets");

  chk_cause_on_release: assert property (
    $rose(proc_n_q) |-> cause_q == $past(pend_q))
    else $error("cause not loaded at processor release");

  chk_cause_stable: assert property (
    proc_n_q && $past(proc_n_q) |-> $stable(cause_q))
    else $error("cause changed while processor runs");

  chk_user_disabled: assert property (
    st_q == ST_RUN && !mode_q.user_en && bk_ok_s && core_ok_s |=> st_q != ST_USER)
    else $error("user reset entered while disabled");

  chk_user_entry: assert property (
    st_q == ST_RUN && user_hit && bk_ok_s && core_ok_s |=> st_q == ST_USER && !proc_rst_n)
    else $error("enabled low pin did not enter user reset");

  chk_seen_set: assert property (
    pin_fall |=> seen_q)
    else $error("pin fall not recorded");

  chk_irq_clear: assert property (
    sr_read && !pin_fall |=> !user_reset_irq && !seen_q)
    else $error("status read did not clear interrupt");

  chk_level_read: assert property (
    sr_read |=> reg_rdata[SR_LEVEL_BIT] == $past(pin_level))
    else $error("pin level misreported");

  chk_boot_sample: assert property (
    $rose(core_ok_s) ##3 1'b1 |=> boot_mode == $past(boot_s))
    else $error("boot pin not sampled three cycles after core rise");

endmodule
`default_nettype wire

// *** tb/srst_board.sv ***
`timescale 1ns/1ns
`default_nettype none
module srst_board (
  // Controls from the bench.
  input  wire logic bkp_good,
  input  wire logic core_good,
  input  wire logic press,
  input  wire logic boot_lvl,
  // Pin drive from the controller.
  input  wire logic nrst_out,
  input  wire logic nrst_oe,
  // Supply cells and board pins.
  output logic      backup_por_n,
  output logic      core_por_n,
  output logic      nrst_in,
  output logic      boot_select_pin
);
  // ----------------------------------------------------------------
  // Supply cells and pulled-up reset pin.
  // ----------------------------------------------------------------
  // The pin has a pull-up and is wired low by the controller or a button.
  assign nrst_in         = !(nrst_oe && !nrst_out) && !press;
  assign backup_por_n    = bkp_good;
  assign core_por_n      = core_good && bkp_good;
  assign boot_select_pin = boot_lvl;
endmodule
`default_nettype wire

// *** tb/srst_ctrl_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module srst_ctrl_bench;
  import srst_pkg::*;
  localparam int unsigned STARTUP = 4;
  logic              clk, rst, bkp_good, core_good, press, boot_lvl;
  logic              backup_por_n, core_por_n, nrst_in, nrst_out, nrst_oe;
  logic              boot_select_pin, proc_rst_n, wdt_rst_n, backup_rst_n;
  logic              periph_rst_n, user_reset_irq, boot_mode, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
  int                error_cnt, checks, cyc, n, m_len, m_uen, m_ien, m_cause;

  // ----------------------------------------------------------------
  // Design and board.
  // ----------------------------------------------------------------
  srst_ctrl #(.STARTUP_CYC(STARTUP)) u_dut (
    .clk(clk), .rst(rst), .backup_por_n(backup_por_n), .core_por_n(core_por_n),
    .nrst_in(nrst_in), .nrst_out(nrst_out), .nrst_oe(nrst_oe),
    .boot_select_pin(boot_select_pin), .proc_rst_n(proc_rst_n), .wdt_rst_n(wdt_rst_n),
    .backup_rst_n(backup_rst_n), .periph_rst_n(periph_rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .user_reset_irq(user_reset_irq), .boot_mode(boot_mode)
  );
  srst_board u_board (
    .bkp_good(bkp_good), .core_good(core_good), .press(press), .boot_lvl(boot_lvl),
    .nrst_out(nrst_out), .nrst_oe(nrst_oe), .backup_por_n(backup_por_n),
    .core_por_n(core_por_n), .nrst_in(nrst_in), .boot_select_pin(boot_select_pin)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and tasks.
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  function automatic logic [DATA_W-1:0] mode_exp();
    return DATA_W'(m_len << MR_LEN_LSB | m_uen << MR_UEN_BIT | m_ien << MR_IEN_BIT);
  endfunction

  task automatic set_mode(input int len, uen, ien);
    m_len = len;
    m_uen = uen;
    m_ien = ien;
    wr(MODE_OFS, mode_exp());
  endtask

  task automatic chk_status(input int seen_exp);
    logic [DATA_W-1:0] exp_val;
    rd(STATUS_OFS, rd_val);
    exp_val = DATA_W'(m_cause << SR_CAUSE_LSB | seen_exp << SR_SEEN_BIT);
    exp_val = exp_val | (DATA_W'(nrst_in) << SR_LEVEL_BIT);
    chk("status", rd_val, exp_val);
  endtask

  task automatic wait_run();
    n = 0;
    while (proc_rst_n !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic pulse_len(input int len);
    n = 0;
    while (nrst_oe === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("pin_pulse", DATA_W'(n), DATA_W'(2 ** (len + 1)));
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hBF32E14C));
    {rst, bkp_good, core_good} = 3'h7;
    {press, boot_lvl, reg_wr, reg_rd} = 4'h0;
    reg_addr  = '0;
    reg_wdata = '0;
    {error_cnt, checks, m_len, m_uen, m_ien} = '0;
    m_cause = CAUSE_GENERAL;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // General reset after power-up.
    wait_run();
    chk("backup_rel", backup_rst_n, 1);
    pulse_len(0);
    rd(STATUS_OFS, rd_val);
    chk_status(0);
    rd(8'h0C, rd_val);
    chk("unmapped", rd_val, 0);
    // User reset with the pin held low past the pulse.
    set_mode(1, 1, 0);
    rd(MODE_OFS, rd_val);
    chk("mode", rd_val, mode_exp());
    press <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk("proc_user", proc_rst_n, 0);
    chk("periph_user", periph_rst_n, 0);
    chk("wdt_user", wdt_rst_n, 0);
    chk("backup_user", backup_rst_n, 1);
    rd(STATUS_OFS, rd_val);
    chk("cause_hold", rd_val >> SR_CAUSE_LSB & 32'h7, DATA_W'(m_cause));
    @(posedge clk);
    press <= 1'b0;
    wait_run();
    repeat (8) @(posedge clk);
    m_cause = CAUSE_USER;
    chk_status(1);
    chk_status(0);
    // User reset disabled, interrupt enabled.
    set_mode(0, 0, 1);
    press <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("proc_off", proc_rst_n, 1);
    chk("irq_set", user_reset_irq, 1);
    chk_status(1);
    chk("irq_clr", user_reset_irq, 0);
    press <= 1'b0;
    repeat (4) @(posedge clk);
    chk_status(0);
    // Wake-up resets with retained mode settings.
    repeat (2) begin
      set_mode($urandom_range(3, 0), 1, 0);
      @(posedge clk);
      core_good <= 1'b0;
      boot_lvl  <= 1'($urandom_range(1, 0));
      #1;
      chk("proc_core", proc_rst_n, 0);
      chk("backup_core", backup_rst_n, 1);
      repeat (5) @(posedge clk);
      core_good <= 1'b1;
      wait_run();
      pulse_len(m_len);
      chk("boot", boot_mode, boot_lvl);
      m_cause = CAUSE_WAKEUP;
      rd(STATUS_OFS, rd_val);
      chk_status(0);
      rd(MODE_OFS, rd_val);
      chk("mode_kept", rd_val, mode_exp());
    end
    // Backup supply loss asserts every reset and clears the mode register.
    @(posedge clk);
    bkp_good <= 1'b0;
    #1;
    chk("all_low", {proc_rst_n, backup_rst_n, periph_rst_n, nrst_oe}, 1);
    wr(MODE_OFS, 32'h00000311);
    repeat (3) @(posedge clk);
    bkp_good <= 1'b1;
    wait_run();
    chk("backup_up", backup_rst_n, 1);
    pulse_len(0);
    {m_len, m_uen, m_ien} = '0;
    m_cause = CAUSE_GENERAL;
    rd(MODE_OFS, rd_val);
    chk("mode_lost", rd_val, mode_exp());
    rd(STATUS_OFS, rd_val);
    chk_status(0);
    test_done();
  end
endmodule
`default_nettype wire
